/* logic/scfg_consts.svh */
// Offsets, field positions, reset values and timing counts for the config bank
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH

`define SCFG_ADDR_W          5
`define SCFG_DATA_W          16
`define SCFG_OFF_PIN_CLK     5'h01
`define SCFG_OFF_FIXED_TWO   5'h02
`define SCFG_OFF_FIXED_THREE 5'h03
`define SCFG_OFF_FIXED_FOUR  5'h04
`define SCFG_OFF_FIXED_FIVE  5'h05
`define SCFG_OFF_FIXED_SIX   5'h06
`define SCFG_OFF_FIXED_SEVEN 5'h07
`define SCFG_OFF_OSC_OVR     5'h08
`define SCFG_OFF_OSC_CUR     5'h10
`define SCFG_RST_PIN_CLK     16'h080c
`define SCFG_RST_FIXED_TWO   16'h0500
`define SCFG_RST_FIXED_THREE 16'h0642
`define SCFG_RST_FIXED_FOUR  16'h0a43
`define SCFG_RST_FIXED_FIVE  16'h00c8
`define SCFG_RST_FIXED_SIX   16'hc802
`define SCFG_RST_FIXED_SEVEN 16'h00b2
`define SCFG_RST_OSC_OVR     16'h2000
`define SCFG_RST_OSC_CUR     16'h0080
`define SCFG_BIT_DRIVE_EN    3
`define SCFG_DIV_LSB         0
`define SCFG_DIV_W           3
`define SCFG_BIT_CUR_OVR     14
`define SCFG_BIT_CAP_OVR     11
`define SCFG_CUR_W           9
`define SCFG_CAP_W           8
`define SCFG_DIV_CNT_W       8
`define SCFG_SM_MAX_MHZ      50

`endif

/* logic/scfg_pkg.sv */
// Types shared by the synthesizer config bank
package scfg_pkg;
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} scfg_req_type;

	typedef struct packed {
		logic [8:0] cur;
		logic [7:0] cap;
	} scfg_osc_type;
endpackage

/* logic/scfg_clk_div.sv */
// Power-of-two divider producing the calibration clock enable
`timescale 1ns/100ps
`default_nettype none
`include "scfg_consts.svh"

module scfg_clk_div
	import scfg_pkg::*;
#(
	parameter int CNT_W = `SCFG_DIV_CNT_W
) (
	input  wire logic       clk_sys_i,  // Oscillator clock
	input  wire logic       rst_i,      // Async reset, high
	input  wire logic       ce_i,       // Clock enable
	input  wire logic [2:0] div_i,      // Exponent of divider
	output var  logic       tick_o      // One pulse per divided period
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} scfg_div_state_type;

	scfg_div_state_type st_r;
	scfg_div_state_type st_nxt;
	logic [CNT_W-1:0]   mask;

	always_comb begin
		// Counting under a mask lets a divider change take effect at once
		mask = CNT_W'((1 << div_i) - 1);
		st_nxt = st_r;
		st_nxt.tick = ((st_r.cnt & mask) == mask);
		st_nxt.cnt = st_r.cnt + 1'b1;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = st_r.tick;
endmodule // scfg_clk_div
`default_nettype wire

/* logic/scfg_regs.sv */
// Synthesizer control bank slice: pin drive, cal clock, fixed words, overrides
`timescale 1ns/100ps
`default_nettype none
`include "scfg_consts.svh"

// Behaviour
// - Drive bit zero tri-states status pin
// - Cal clock is oscillator over two^div
// - Current override selects programmed current
// - Capbank override selects programmed code
// - Programmed current from nine-bit field
module scfg_regs
	import scfg_pkg::*;
(
	input  wire logic        clk_sys_i,       // Oscillator clock, 200 MHz
	input  wire logic        rst_i,           // Async reset, high
	input  wire logic        ce_i,            // Clock enable
	input  wire logic [4:0]  addr_i,          // Register offset
	input  wire logic [15:0] wdata_i,         // Write data
	input  wire logic        wr_i,            // Write strobe
	input  wire logic        rd_i,            // Read strobe
	output var  logic [15:0] rdata_o,         // Read data, cycle after rd
	input  wire logic        status_src_i,    // Internal status level
	output var  logic        status_output_pin_o,  // Status pin out
	output var  logic        status_output_pin_oe_o, // Status pin enable
	input  wire logic [8:0]  cal_cur_i,       // Calibrated current
	input  wire logic [7:0]  cal_cap_i,       // Calibrated capbank
	input  wire logic [7:0]  prog_cap_i,      // Programmed capbank code
	output var  logic [8:0]  osc_current_setting_o, // Applied current
	output var  logic [7:0]  osc_capbank_code_o,    // Applied capbank
	output var  logic        cal_tick_o       // Cal state machine enable
);
	//==========================================================
	// State
	typedef struct packed {
		logic [15:0]  pin_clk;
		logic [15:0]  fx2;
		logic [15:0]  fx3;
		logic [15:0]  fx4;
		logic [15:0]  fx5;
		logic [15:0]  fx6;
		logic [15:0]  fx7;
		logic [15:0]  ovr;
		logic [15:0]  cur;
		logic [15:0]  rdata;
		logic         pin;
		logic         pin_oe;
		scfg_osc_type osc;
		logic         tick;
	} scfg_state_type;

	// One select bit per mapped word, shared by write and read paths
	typedef struct packed {
		logic pin_clk;
		logic fx2;
		logic fx3;
		logic fx4;
		logic fx5;
		logic fx6;
		logic fx7;
		logic ovr;
		logic cur;
	} scfg_sel_type;

	scfg_state_type st_r;
	scfg_state_type st_nxt;
	scfg_req_type   req;
	logic           div_tick;
	scfg_sel_type   wr_sel;
	scfg_sel_type   rd_sel;
	logic [2:0]     div_exp;
	logic           drive_en;
	logic           cur_force;
	logic           cap_force;
	logic [8:0]     cur_prog;

	localparam scfg_state_type ST_RST = '{
		pin_clk: `SCFG_RST_PIN_CLK,
		fx2:     `SCFG_RST_FIXED_TWO,
		fx3:     `SCFG_RST_FIXED_THREE,
		fx4:     `SCFG_RST_FIXED_FOUR,
		fx5:     `SCFG_RST_FIXED_FIVE,
		fx6:     `SCFG_RST_FIXED_SIX,
		fx7:     `SCFG_RST_FIXED_SEVEN,
		ovr:     `SCFG_RST_OSC_OVR,
		cur:     `SCFG_RST_OSC_CUR,
		rdata:   16'h0000,
		pin:     1'b0,
		pin_oe:  1'b0,
		osc:     '0,
		tick:    1'b0
	};

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	//==========================================================
	// Calibration clock divider
	scfg_clk_div #(
		.CNT_W (`SCFG_DIV_CNT_W)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.div_i     (div_exp),
		.tick_o    (div_tick)
	);

	//==========================================================
	// Address decode, shared by write and read paths so that the
	// two can never disagree about which offsets are mapped
	function automatic scfg_sel_type reg_dec(input logic [4:0] a);
		reg_dec = '0;
		case (a)
			`SCFG_OFF_PIN_CLK:     reg_dec.pin_clk = 1'b1;
			`SCFG_OFF_FIXED_TWO:   reg_dec.fx2 = 1'b1;
			`SCFG_OFF_FIXED_THREE: reg_dec.fx3 = 1'b1;
			`SCFG_OFF_FIXED_FOUR:  reg_dec.fx4 = 1'b1;
			`SCFG_OFF_FIXED_FIVE:  reg_dec.fx5 = 1'b1;
			`SCFG_OFF_FIXED_SIX:   reg_dec.fx6 = 1'b1;
			`SCFG_OFF_FIXED_SEVEN: reg_dec.fx7 = 1'b1;
			`SCFG_OFF_OSC_OVR:     reg_dec.ovr = 1'b1;
			`SCFG_OFF_OSC_CUR:     reg_dec.cur = 1'b1;
			// Unmapped offsets select nothing
			default:               reg_dec = '0;
		endcase
	endfunction

	//==========================================================
	// Whole-word update of one register
	function automatic logic [15:0] wr_word(input logic [15:0] old,
		input logic [15:0] d, input logic hit);
		wr_word = hit ? d : old;
	endfunction

	//==========================================================
	// Register writes; reserved bits are kept as written, since
	// software owns their values and the bank does not police them
	function automatic scfg_state_type apply_wr(input scfg_state_type s,
		input scfg_sel_type sel, input logic [15:0] d);
		apply_wr = s;
		apply_wr.pin_clk = wr_word(s.pin_clk, d, sel.pin_clk);
		apply_wr.fx2 = wr_word(s.fx2, d, sel.fx2);
		apply_wr.fx3 = wr_word(s.fx3, d, sel.fx3);
		apply_wr.fx4 = wr_word(s.fx4, d, sel.fx4);
		apply_wr.fx5 = wr_word(s.fx5, d, sel.fx5);
		apply_wr.fx6 = wr_word(s.fx6, d, sel.fx6);
		apply_wr.fx7 = wr_word(s.fx7, d, sel.fx7);
		apply_wr.ovr = wr_word(s.ovr, d, sel.ovr);
		apply_wr.cur = wr_word(s.cur, d, sel.cur);
	endfunction

	//==========================================================
	// Read mux; the select is one-hot or empty, so an OR of masked
	// words suffices and an empty select reads as zero
	function automatic logic [15:0] rd_mux(input scfg_state_type s,
		input scfg_sel_type sel);
		rd_mux = 16'h0000;
		rd_mux = rd_mux | ({16{sel.pin_clk}} & s.pin_clk);
		rd_mux = rd_mux | ({16{sel.fx2}} & s.fx2);
		rd_mux = rd_mux | ({16{sel.fx3}} & s.fx3);
		rd_mux = rd_mux | ({16{sel.fx4}} & s.fx4);
		rd_mux = rd_mux | ({16{sel.fx5}} & s.fx5);
		rd_mux = rd_mux | ({16{sel.fx6}} & s.fx6);
		rd_mux = rd_mux | ({16{sel.fx7}} & s.fx7);
		rd_mux = rd_mux | ({16{sel.ovr}} & s.ovr);
		rd_mux = rd_mux | ({16{sel.cur}} & s.cur);
	endfunction

	//==========================================================
	// Oscillator setting select: a forced value replaces the
	// calibration result only while its override bit is set
	function automatic scfg_osc_type osc_sel(input logic cur_frc,
		input logic [8:0] cur_prg, input logic [8:0] cur_cal,
		input logic cap_frc, input logic [7:0] cap_prg,
		input logic [7:0] cap_cal);
		osc_sel.cur = cur_frc ? cur_prg : cur_cal;
		osc_sel.cap = cap_frc ? cap_prg : cap_cal;
	endfunction

	//==========================================================
	// Decoded strobes and control fields
	assign wr_sel = req.wr ? reg_dec(req.addr) : scfg_sel_type'('0);
	assign rd_sel = req.rd ? reg_dec(req.addr) : scfg_sel_type'('0);
	assign div_exp = st_r.pin_clk[`SCFG_DIV_LSB +: `SCFG_DIV_W];
	assign drive_en = st_r.pin_clk[`SCFG_BIT_DRIVE_EN];
	assign cur_force = st_r.ovr[`SCFG_BIT_CUR_OVR];
	assign cap_force = st_r.ovr[`SCFG_BIT_CAP_OVR];
	assign cur_prog = st_r.cur[`SCFG_CUR_W-1:0];

	//==========================================================
	// Next state
	always_comb begin
		st_nxt = apply_wr(st_r, wr_sel, req.wdata);
		// Read data stand for one cycle only, zero otherwise
		st_nxt.rdata = rd_mux(st_r, rd_sel);
		st_nxt.pin = status_src_i;
		st_nxt.pin_oe = drive_en;
		st_nxt.osc = osc_sel(cur_force, cur_prog, cal_cur_i,
			cap_force, prog_cap_i, cal_cap_i);
		st_nxt.tick = div_tick;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	//==========================================================
	// Outputs, all registered
	assign rdata_o = st_r.rdata;
	assign status_output_pin_o = st_r.pin;
	assign status_output_pin_oe_o = st_r.pin_oe;
	assign osc_current_setting_o = st_r.osc.cur;
	assign osc_capbank_code_o = st_r.osc.cap;
	assign cal_tick_o = st_r.tick;
endmodule // scfg_regs
`default_nettype wire

/* testbench/scfg_regs_chk.sv */
// Port assertions for the synthesizer config bank
`timescale 1ns/100ps
`default_nettype none
module scfg_regs_chk (
	input wire logic        clk_sys_i,              // Clock
	input wire logic        rst_i,                  // Reset
	input wire logic        ce_i,                   // Enable
	input wire logic [4:0]  addr_i,                 // Offset
	input wire logic [15:0] wdata_i,                // Wdata
	input wire logic        wr_i,                   // Write
	input wire logic        rd_i,                   // Read
	input wire logic [15:0] rdata_o,                // Rdata
	input wire logic        status_src_i,           // Status
	input wire logic        status_output_pin_o,    // Pin
	input wire logic        status_output_pin_oe_o, // Pin enable
	input wire logic [8:0]  cal_cur_i,              // Cal current
	input wire logic [7:0]  cal_cap_i,              // Cal capbank
	input wire logic [7:0]  prog_cap_i,             // Prog capbank
	input wire logic [8:0]  osc_current_setting_o,  // Current
	input wire logic [7:0]  osc_capbank_code_o,     // Capbank
	input wire logic        cal_tick_o              // Tick
);
	// ====================
	// Shadow fields, updated on the same edge as the bank
	logic       cur_ovr_r;
	logic       cap_ovr_r;
	logic [8:0] cur_val_r;
	logic [2:0] div_r;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			{cur_ovr_r, cap_ovr_r, cur_val_r, div_r} <= {2'h0, 9'h080, 3'h4};
		end else if (ce_i && wr_i) begin
			if (addr_i == 5'h08) cur_ovr_r <= wdata_i[14];
			if (addr_i == 5'h08) cap_ovr_r <= wdata_i[11];
			if (addr_i == 5'h10) cur_val_r <= wdata_i[8:0];
			if (addr_i == 5'h01) div_r <= wdata_i[2:0];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	pin_follow_a: assert property (!rst_i && ce_i |=>
		status_output_pin_o == $past(status_src_i))
		else $error("status pin does not follow source");
	pin_drive_a: assert property ((ce_i && wr_i && addr_i == 5'h01) ##1 ce_i
		|=> status_output_pin_oe_o == $past(wdata_i[3], 2)) else $error("pin enable wrong");
	tick_period_a: assert property ((cal_tick_o && ce_i && div_r == 3'h2 && !wr_i)
		##1 (ce_i && !wr_i)[*4] |-> cal_tick_o && !$past(cal_tick_o)
		&& !$past(cal_tick_o, 2) && !$past(cal_tick_o, 3)) else $error("tick period wrong");
	cur_sel_a: assert property (!rst_i && ce_i |=> osc_current_setting_o
		== $past(cur_ovr_r ? cur_val_r : cal_cur_i)) else $error("current select wrong");
	cap_sel_a: assert property (!rst_i && ce_i |=> osc_capbank_code_o
		== $past(cap_ovr_r ? prog_cap_i : cal_cap_i)) else $error("capbank select wrong");
	read_back_a: assert property ((ce_i && wr_i && addr_i == 5'h07) ##2 (rd_i && ce_i
		&& addr_i == 5'h07) |=> rdata_o == $past(wdata_i, 3)) else $error("readback wrong");
	read_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
		else $error("read data not idle");
	unmapped_a: assert property (ce_i && rd_i && addr_i == 5'h1f |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
endmodule // scfg_regs_chk
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the synthesizer config bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ====================
	// Stimulus and design
	logic        clk_sys_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0;
	logic        status_src_i = 0, status_output_pin_o, status_output_pin_oe_o;
	logic        cal_tick_o;
	logic [4:0]  addr_i = 5'h00;
	logic [15:0] wdata_i = 16'h0000, rdata_o;
	logic [8:0]  cal_cur_i = 9'h0aa, osc_current_setting_o;
	logic [7:0]  cal_cap_i = 8'h33, prog_cap_i = 8'hcc, osc_capbank_code_o;
	logic [15:0] rst_tab [1:8] = '{16'h080c, 16'h0500, 16'h0642, 16'h0a43,
		16'h00c8, 16'hc802, 16'h00b2, 16'h2000};
	logic [15:0] rec_tab [2:7] = '{16'h0500, 16'h0642, 16'h0e43, 16'h03e8,
		16'h7802, 16'h00b2};
	int          fails = 0, checks = 0, n;
	scfg_regs uut (.clk_sys_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .status_src_i, .status_output_pin_o, .status_output_pin_oe_o,
		.cal_cur_i, .cal_cap_i, .prog_cap_i, .osc_current_setting_o,
		.osc_capbank_code_o, .cal_tick_o);
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) status_src_i <= ~status_src_i;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, exp);
	endtask
	task automatic stop_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int a = 1; a <= 8; a++) rd_reg(5'(a), rst_tab[a]);
		rd_reg(5'h10, 16'h0080);
		for (int a = 2; a <= 7; a++)
			wr_reg(5'(a), rec_tab[a]);
		for (int a = 2; a <= 7; a++) rd_reg(5'(a), rec_tab[a]);
		$display("test reset and load done");
		// Drive off, divider two keeps 200 MHz down to 50 MHz
		wr_reg(5'h01, 16'h0802);
		repeat (3) @(posedge clk_sys_i);
		n = 0;
		repeat (16) @(posedge clk_sys_i) #1 if (cal_tick_o === 1'b1) n++;
		check(16'(n), 16'h0004);
		check({15'h0, status_output_pin_oe_o}, 16'h0000);
		wr_reg(5'h01, 16'h080a);
		repeat (3) @(posedge clk_sys_i);
		#1 check({15'h0, status_output_pin_oe_o}, 16'h0001);
		check({15'h0, status_output_pin_o}, {15'h0, ~status_src_i});
		$display("test pin and divider done");
		wr_reg(5'h10, 16'h0155);
		wr_reg(5'h08, 16'h6800);
		repeat (3) @(posedge clk_sys_i);
		#1 check({7'h0, osc_current_setting_o}, 16'h0155);
		check({8'h0, osc_capbank_code_o}, 16'h00cc);
		wr_reg(5'h08, 16'h2000);
		repeat (3) @(posedge clk_sys_i);
		#1 check({7'h0, osc_current_setting_o}, 16'h00aa);
		check({8'h0, osc_capbank_code_o}, 16'h0033);
		$display("test overrides done");
		wr_reg(5'h1f, 16'hffff);
		rd_reg(5'h1f, 16'h0000);
		wr_reg(5'h07, 16'h5a5a);
		rd_reg(5'h07, 16'h5a5a);
		@(posedge clk_sys_i) ce_i <= 1'b0;
		wr_reg(5'h02, 16'h1234);
		@(posedge clk_sys_i) ce_i <= 1'b1;
		rd_reg(5'h02, 16'h0500);
		@(posedge clk_sys_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd_reg(5'h04, 16'h0a43);
		rd_reg(5'h01, 16'h080c);
		$display("test access and reset done");
		stop_test;
	end
endmodule // testbench
bind scfg_regs scfg_regs_chk chk (.clk_sys_i, .rst_i, .ce_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .status_src_i, .status_output_pin_o,
	.status_output_pin_oe_o, .cal_cur_i, .cal_cap_i, .prog_cap_i,
	.osc_current_setting_o, .osc_capbank_code_o, .cal_tick_o);
`default_nettype wire
